// >>> rtl/rtccs_pkg.sv
// Purpose: Constants for the calendar and status register bank
// Assumes: Byte-wide registers at their printed addresses
// Notes: Addresses, field positions, reset values, masks, limits and settle timing
package rtccs_pkg;
    localparam logic [7:0] ADDR_SECONDS = 8'h01;
    localparam logic [7:0] ADDR_HOURS = 8'h03;
    localparam logic [7:0] ADDR_WEEKDAY = 8'h04;
    localparam logic [7:0] ADDR_DATE = 8'h05;
    localparam logic [7:0] ADDR_MONTH = 8'h06;
    localparam logic [7:0] ADDR_YEAR = 8'h07;
    localparam int START_BIT = 7;
    localparam int OSC_RUN_BIT = 5;
    localparam int PWR_LOSS_BIT = 4;
    localparam int VBAT_EN_BIT = 3;
    localparam int LEAP_BIT = 5;
    localparam logic [7:0] WEEKDAY_RESET = 8'h01;
    localparam logic [7:0] DATE_RESET = 8'h01;
    localparam logic [7:0] MONTH_RESET = 8'h01;
    localparam logic [7:0] YEAR_RESET = 8'h01;
    localparam logic [2:0] WEEKDAY_MIN = 3'h1;
    localparam logic [2:0] WEEKDAY_MAX = 3'h7;
    localparam logic [7:0] WEEKDAY_MASK = 8'h0f;
    localparam logic [7:0] DATE_MASK = 8'h3f;
    localparam logic [7:0] MONTH_MASK = 8'h1f;
    localparam logic [7:0] YEAR_MASK = 8'hff;
    // Oscillator settle time before the running flag rises
    localparam int OSC_SETTLE_US = 10;
    localparam int CLK_MHZ = 50;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
    localparam logic [15:0] OSC_SETTLE_COUNT = 16'(OSC_SETTLE_CYC);
endpackage

// >>> rtl/rtccs_leap.sv
// Purpose: Leap year decode from the two BCD year digits
// Assumes: Year is 20YY, so every fourth year is a leap year
// Notes: Pure combinational
`timescale 1ns/1ps
module rtccs_leap (
    input wire logic [7:0] year_bcd,
    output logic leap
);
    logic [3:0] tens;
    logic [3:0] ones;
    always_comb begin
        tens = year_bcd[7:4];
        ones = year_bcd[3:0];
        // Divisible by 4: tens even needs ones in 0,4,8; odd needs 2,6
        if (tens[0] == 1'b0) begin
            leap = (ones == 4'h0) || (ones == 4'h4) || (ones == 4'h8);
        end else begin
            leap = (ones == 4'h2) || (ones == 4'h6);
        end
    end
endmodule

// >>> rtl/rtccs_regs.sv
// Purpose: Weekday, date, month, year and status registers
// Assumes: Byte register port from the serial slave on clk
// Notes: Rollover strobes arrive from same-clock counter logic
//
// Behaviour
// - Date tens digit in bits 5-4
// - Date ones digit in bits 3-0
// - Month tens digit single bit 4
// - Month ones digit in bits 3-0
// - Read-only leap flag, month bit 5
// - Year tens digit in bits 7-4
// - Year ones digit in bits 3-0
// - Power loss sets flag, timestamp locked
// - Writing zero clears flag and timestamps
// - Unimplemented bits read as zero
// - Values held in BCD form
// - Start bit enables oscillator
`timescale 1ns/1ps
module rtccs_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic day_carry,
    input wire logic power_lost,
    input wire logic battery_present,
    output logic osc_enable,
    output logic timestamp_load,
    output logic timestamp_clear,
    output logic battery_select
);
    logic [2:0] day_of_week_value;
    logic [1:0] date_tens_digit;
    logic [3:0] date_ones_digit;
    logic month_tens_digit;
    logic [3:0] month_ones_digit;
    logic [3:0] year_tens_digit;
    logic [3:0] year_ones_digit;
    logic power_loss_flag;
    logic battery_backup_enable;
    logic oscillator_start_bit;
    logic osc_running_flag;
    logic [15:0] settle_cnt;
    logic lost_s1, lost_s2, lost_s3;
    logic bat_s1, bat_s2;
    logic leap_year_flag;
    logic [7:0] year_byte;

    logic [2:0] next_dow;
    logic [1:0] next_dten;
    logic [3:0] next_done;
    logic next_mten;
    logic [3:0] next_mone;
    logic [3:0] next_yten;
    logic [3:0] next_yone;
    logic next_pwr;
    logic next_vbat;
    logic next_start;
    logic next_run;
    logic [15:0] next_settle;
    logic [7:0] next_rdata;
    logic next_ts_load;
    logic next_ts_clear;
    logic next_bat_sel;

    assign year_byte = {year_tens_digit, year_ones_digit};

    rtccs_leap u_leap (
        .year_bcd(year_byte),
        .leap(leap_year_flag)
    );

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    function automatic logic [7:0] days_in_month(input logic mt,
                                                 input logic [3:0] mo,
                                                 input logic lp);
        logic [7:0] m;
        m = {3'h0, mt, mo};
        case (m)
            8'h02: days_in_month = lp ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: days_in_month = 8'h30;
            default: days_in_month = 8'h31;
        endcase
    endfunction

    always_comb begin
        logic wr_wk;
        logic wr_dt;
        logic wr_mo;
        logic wr_yr;
        logic wr_sec;
        logic lost_rise;
        logic [7:0] date_now;
        wr_wk = reg_wr && hit(reg_addr, rtccs_pkg::ADDR_WEEKDAY);
        wr_dt = reg_wr && hit(reg_addr, rtccs_pkg::ADDR_DATE);
        wr_mo = reg_wr && hit(reg_addr, rtccs_pkg::ADDR_MONTH);
        wr_yr = reg_wr && hit(reg_addr, rtccs_pkg::ADDR_YEAR);
        wr_sec = reg_wr && hit(reg_addr, rtccs_pkg::ADDR_SECONDS);
        lost_rise = lost_s2 && !lost_s3;
        date_now = {2'h0, date_tens_digit, date_ones_digit};
        next_dow = day_of_week_value;
        next_dten = date_tens_digit;
        next_done = date_ones_digit;
        next_mten = month_tens_digit;
        next_mone = month_ones_digit;
        next_yten = year_tens_digit;
        next_yone = year_ones_digit;
        next_pwr = power_loss_flag;
        next_vbat = battery_backup_enable;
        next_start = oscillator_start_bit;
        next_ts_load = 1'b0;
        next_ts_clear = 1'b0;

        // Calendar advance on day carry, BCD arithmetic throughout
        if (day_carry) begin
            if (day_of_week_value >= rtccs_pkg::WEEKDAY_MAX) begin
                next_dow = rtccs_pkg::WEEKDAY_MIN;
            end else begin
                next_dow = day_of_week_value + 3'h1;
            end
            if (date_now == days_in_month(month_tens_digit,
                                          month_ones_digit,
                                          leap_year_flag)) begin
                next_dten = 2'h0;
                next_done = 4'h1;
                if (month_tens_digit && month_ones_digit == 4'h2) begin
                    next_mten = 1'b0;
                    next_mone = 4'h1;
                    if (year_ones_digit == 4'h9) begin
                        next_yone = 4'h0;
                        next_yten = (year_tens_digit == 4'h9) ? 4'h0 :
                            year_tens_digit + 4'h1;
                    end else begin
                        next_yone = year_ones_digit + 4'h1;
                    end
                end else if (month_ones_digit == 4'h9) begin
                    next_mten = 1'b1;
                    next_mone = 4'h0;
                end else begin
                    next_mone = month_ones_digit + 4'h1;
                end
            end else if (date_ones_digit == 4'h9) begin
                next_done = 4'h0;
                next_dten = date_tens_digit + 2'h1;
            end else begin
                next_done = date_ones_digit + 4'h1;
            end
        end

        // Software writes win over the carry in the same cycle
        if (wr_wk) begin
            next_dow = reg_wdata[2:0];
            next_vbat = reg_wdata[rtccs_pkg::VBAT_EN_BIT];
            if (!reg_wdata[rtccs_pkg::PWR_LOSS_BIT]) begin
                next_pwr = 1'b0;
                next_ts_clear = 1'b1;
            end
        end
        if (wr_dt) begin
            next_dten = reg_wdata[5:4];
            next_done = reg_wdata[3:0];
        end
        if (wr_mo) begin
            next_mten = reg_wdata[4];
            next_mone = reg_wdata[3:0];
        end
        if (wr_yr) begin
            next_yten = reg_wdata[7:4];
            next_yone = reg_wdata[3:0];
        end
        if (wr_sec) begin
            next_start = reg_wdata[rtccs_pkg::START_BIT];
        end

        // Set wins over clear; a locked flag skips the new load but lets a zero write clear the timestamp
        if (lost_rise && !power_loss_flag) begin
            next_pwr = 1'b1;
            next_ts_load = 1'b1;
            next_ts_clear = 1'b0;
        end else if (lost_rise) begin
            next_pwr = 1'b1;
        end

        // Battery only when enabled, present and primary lost
        next_bat_sel = battery_backup_enable && bat_s2 && lost_s2;
    end

    // Running flag waits for settle; a cleared start bit drops it at once
    always_comb begin
        next_run = osc_running_flag;
        next_settle = settle_cnt;
        if (!oscillator_start_bit) begin
            next_settle = 16'h0000;
            next_run = 1'b0;
        end else if (settle_cnt >= rtccs_pkg::OSC_SETTLE_COUNT) begin
            next_run = 1'b1;
        end else begin
            next_settle = settle_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_running_flag <= 1'b0;
            settle_cnt <= 16'h0000;
        end else begin
            osc_running_flag <= next_run;
            settle_cnt <= next_settle;
        end
    end

    // Registered read data, zero except in the cycle after a read
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                rtccs_pkg::ADDR_WEEKDAY: next_rdata = {2'h0,
                    osc_running_flag, power_loss_flag,
                    battery_backup_enable, day_of_week_value};
                rtccs_pkg::ADDR_DATE: next_rdata = {2'h0,
                    date_tens_digit, date_ones_digit};
                rtccs_pkg::ADDR_MONTH: next_rdata = {2'h0,
                    leap_year_flag, month_tens_digit,
                    month_ones_digit};
                rtccs_pkg::ADDR_YEAR: next_rdata = year_byte;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Pins are asynchronous, two stages before use
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lost_s1 <= 1'b0;
            lost_s2 <= 1'b0;
            lost_s3 <= 1'b0;
            bat_s1 <= 1'b0;
            bat_s2 <= 1'b0;
        end else begin
            lost_s1 <= power_lost;
            lost_s2 <= lost_s1;
            lost_s3 <= lost_s2;
            bat_s1 <= battery_present;
            bat_s2 <= bat_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            day_of_week_value <= rtccs_pkg::WEEKDAY_RESET[2:0];
            date_tens_digit <= rtccs_pkg::DATE_RESET[5:4];
            date_ones_digit <= rtccs_pkg::DATE_RESET[3:0];
            month_tens_digit <= rtccs_pkg::MONTH_RESET[4];
            month_ones_digit <= rtccs_pkg::MONTH_RESET[3:0];
            year_tens_digit <= rtccs_pkg::YEAR_RESET[7:4];
            year_ones_digit <= rtccs_pkg::YEAR_RESET[3:0];
            power_loss_flag <= 1'b0;
            battery_backup_enable <= 1'b0;
            oscillator_start_bit <= 1'b0;
            timestamp_load <= 1'b0;
            timestamp_clear <= 1'b0;
            battery_select <= 1'b0;
            osc_enable <= 1'b0;
        end else begin
            day_of_week_value <= next_dow;
            date_tens_digit <= next_dten;
            date_ones_digit <= next_done;
            month_tens_digit <= next_mten;
            month_ones_digit <= next_mone;
            year_tens_digit <= next_yten;
            year_ones_digit <= next_yone;
            power_loss_flag <= next_pwr;
            battery_backup_enable <= next_vbat;
            oscillator_start_bit <= next_start;
            timestamp_load <= next_ts_load;
            timestamp_clear <= next_ts_clear;
            battery_select <= next_bat_sel;
            osc_enable <= next_start;
        end
    end
endmodule

// >>> testbench/rtccs_host_model.sv
// Purpose: Host side of the byte register port
// Assumes: Strobes launched on the falling edge, taken on the rising
// Notes: Read data sampled in its single valid cycle
`timescale 1ns/1ps
module rtccs_host_model (
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    logic busy = 1'b0;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Idle bus shows a moving pattern so stale bytes never match
    // Frozen from the edge before a write, so data has a single driver
    always @(negedge clk) begin
        if (!busy) begin
            reg_wdata <= ~reg_wdata;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busy = 1'b1;
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        busy = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// >>> testbench/rtccs_regs_sva.sv
// Purpose: Port-level checks of the calendar register bank
// Assumes: One clock domain, async low reset
// Notes: Status flags needing history are checked by the bench
`timescale 1ns/1ps
module rtccs_regs_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic day_carry,
    input wire logic power_lost,
    input wire logic battery_present,
    input wire logic osc_enable,
    input wire logic timestamp_load,
    input wire logic timestamp_clear,
    input wire logic battery_select
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    high_bits_a: assert property (reg_rd && reg_addr >= 8'h04 &&
        reg_addr <= 8'h06 |=> reg_rdata[7:6] == 2'h0)
        else $error("unimplemented bits read nonzero");
    date_tens_a: assert property (reg_rd && reg_addr == 8'h05
        |=> reg_rdata[5:4] != 2'h3 || reg_rdata[3:0] <= 4'h1)
        else $error("date tens out of range");
    start_bit_a: assert property (reg_wr && reg_addr == 8'h01
        |=> osc_enable == $past(reg_wdata[7]))
        else $error("oscillator enable not from start bit");
    weekday_back_a: assert property (reg_wr && reg_addr == 8'h04
        ##1 !reg_wr && !day_carry ##1 reg_rd && reg_addr == 8'h04
        |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 3))
        else $error("weekday field readback wrong");
    clear_cause_a: assert property (timestamp_clear |->
        $past(reg_wr) && $past(reg_addr) == 8'h04 && !$past(reg_wdata[4]))
        else $error("timestamp clear without zero write");
    load_pulse_a: assert property (timestamp_load
        |-> !timestamp_clear ##1 !timestamp_load)
        else $error("timestamp load not a lone pulse");
    batt_src_a: assert property (battery_select |->
        $past(battery_present, 3) && $past(power_lost, 3))
        else $error("battery selected without cause");
endmodule
bind rtccs_regs rtccs_regs_sva u_sva (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .day_carry(day_carry),
    .power_lost(power_lost), .battery_present(battery_present),
    .osc_enable(osc_enable), .timestamp_load(timestamp_load),
    .timestamp_clear(timestamp_clear), .battery_select(battery_select));

// >>> testbench/rtccs_regs_tb.sv
// Purpose: Directed register tests of the calendar bank
// Assumes: Host model drives the register port
// Notes: Settle wait is fixed at 500 cycles, so osc test is short
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, e); end end
module rtccs_regs_tb;
    logic clk, rst_n, day_carry, power_lost, battery_present;
    logic reg_wr, reg_rd, osc_enable, timestamp_load;
    logic timestamp_clear, battery_select;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int fail_count = 0;
    int checked = 0;
    int n;
    rtccs_host_model u_rtccs_host_model (.clk(clk), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    rtccs_regs u_rtccs_regs (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .day_carry(day_carry),
        .power_lost(power_lost), .battery_present(battery_present),
        .osc_enable(osc_enable), .timestamp_load(timestamp_load),
        .timestamp_clear(timestamp_clear), .battery_select(battery_select));
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        u_rtccs_host_model.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic carry();
        @(negedge clk) day_carry = 1'b1;
        @(negedge clk) day_carry = 1'b0;
    endtask
    task automatic count_load();
        n = 0;
        repeat (20) @(negedge clk) n += int'(timestamp_load);
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {rst_n, day_carry, power_lost, battery_present} = 4'b0001;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        rc(8'h04, 8'h01);
        rc(8'h05, 8'h01);
        rc(8'h06, 8'h01);
        rc(8'h07, 8'h01);
        rc(8'h08, 8'h00);
        rc(8'h01, 8'h00);
        $display("reset values done");
        u_rtccs_host_model.wr(8'h04, 8'h07);
        u_rtccs_host_model.wr(8'h05, 8'h28);
        u_rtccs_host_model.wr(8'h06, 8'hc2);
        u_rtccs_host_model.wr(8'h07, 8'h23);
        rc(8'h06, 8'h02);
        carry();
        rc(8'h04, 8'h01);
        rc(8'h05, 8'h01);
        rc(8'h06, 8'h03);
        u_rtccs_host_model.wr(8'h05, 8'h28);
        u_rtccs_host_model.wr(8'h06, 8'h02);
        u_rtccs_host_model.wr(8'h07, 8'h24);
        rc(8'h06, 8'h22);
        carry();
        rc(8'h05, 8'h29);
        u_rtccs_host_model.wr(8'h05, 8'h31);
        u_rtccs_host_model.wr(8'h06, 8'h12);
        u_rtccs_host_model.wr(8'h07, 8'h99);
        carry();
        rc(8'h07, 8'h00);
        rc(8'h06, 8'h21);
        rc(8'h05, 8'h01);
        u_rtccs_host_model.wr(8'h05, 8'h30);
        u_rtccs_host_model.wr(8'h06, 8'h09);
        carry();
        rc(8'h06, 8'h30);
        u_rtccs_host_model.wr(8'h05, 8'h09);
        carry();
        rc(8'h05, 8'h10);
        $display("calendar done");
        u_rtccs_host_model.wr(8'h04, 8'h09);
        power_lost = 1'b1;
        count_load();
        `CHK(n, 1)
        `CHK(battery_select, 1'b1)
        rc(8'h04, 8'h19);
        u_rtccs_host_model.wr(8'h04, 8'h19);
        rc(8'h04, 8'h19);
        power_lost = 1'b0;
        repeat (5) @(negedge clk);
        `CHK(battery_select, 1'b0)
        u_rtccs_host_model.wr(8'h04, 8'h09);
        `CHK(timestamp_clear, 1'b1)
        rc(8'h04, 8'h09);
        power_lost = 1'b1;
        count_load();
        `CHK(n, 1)
        u_rtccs_host_model.wr(8'h04, 8'h01);
        @(negedge clk);
        `CHK(battery_select, 1'b0)
        power_lost = 1'b0;
        $display("power loss done");
        u_rtccs_host_model.wr(8'h01, 8'h80);
        `CHK(osc_enable, 1'b1)
        rc(8'h04, 8'h01);
        repeat (520) @(negedge clk);
        rc(8'h04, 8'h21);
        u_rtccs_host_model.wr(8'h01, 8'h00);
        `CHK(osc_enable, 1'b0)
        repeat (3) @(negedge clk);
        rc(8'h04, 8'h01);
        $display("oscillator done");
        report_and_stop();
    end
endmodule
